// file: core/pmc_pkg.sv
package pmc_pkg;
  localparam logic [7:0] power_mgmt_control_addr = 8'h14;
  localparam int skip_analog_ref_wait_bit = 15;
  localparam int osc_suspend_block_bit = 14;
  localparam int lpi_wake_enable_bit = 13;
  localparam int lpi_wake_flag_bit = 12;
  localparam int mac_domain_reset_bit = 11;
  localparam int resume_clears_wake_flags_bit = 9;
  localparam int resume_clears_wake_enables_bit = 8;
  localparam int device_ready_bit = 7;
  localparam int sleep_mode_lsb = 5;
  localparam int phy_reset_pulse_bit = 4;
  localparam logic [1:0] sleep_mode_reset = 2'h2;
  localparam logic resume_clears_wake_enables_reset = 1'b1;
  localparam logic skip_analog_ref_wait_reset = 1'b0;
  localparam int clk_mhz = 40;
  localparam int phy_reset_min_ms = 4;
  localparam int analog_ref_settle_ms = 100;
  localparam int phy_reset_long_ms = 128;
  localparam int phy_reset_min_cycles = phy_reset_min_ms * clk_mhz * 1000;
  localparam int phy_reset_long_cycles = phy_reset_long_ms * clk_mhz * 1000;
  localparam int settle_cycles = analog_ref_settle_ms * clk_mhz * 1000;
  localparam int cnt_w = 24;
endpackage

// file: core/pmc_sync3.sv
`timescale 1ns/10ps
`default_nettype none
module pmc_sync3 (
  input wire logic i_clk,
  input wire logic i_reset_n,
  input wire logic i_async,
  output logic o_level
);
  logic s1_reg, s2_reg, s3_reg;
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      s1_reg <= 1'b0;
      s2_reg <= 1'b0;
      s3_reg <= 1'b0;
      o_level <= 1'b0;
    end else begin
      s1_reg <= i_async;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      if (s2_reg == s3_reg) begin
        o_level <= s3_reg;
      end
    end
  end
endmodule // pmc_sync3
`default_nettype wire

// file: core/pmc_timer.sv
`timescale 1ns/10ps
`default_nettype none
module pmc_timer (
  input wire logic i_clk,
  input wire logic i_reset_n,
  input wire logic i_start,
  input wire logic [23:0] i_load,
  output logic o_busy
);
  logic [23:0] cnt_reg;
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      cnt_reg <= 24'h000000;
    end else if (i_start) begin
      cnt_reg <= i_load;
    end else if (cnt_reg != 24'h000000) begin
      cnt_reg <= cnt_reg - 24'h000001;
    end
  end
  assign o_busy = (cnt_reg != 24'h000000);
endmodule // pmc_timer
`default_nettype wire

// file: core/power_mgmt_control_reg.sv
`timescale 1ns/10ps
`default_nettype none
module power_mgmt_control_reg #(
  parameter int phy_reset_min_cycles_p = pmc_pkg::phy_reset_min_cycles,
  parameter int phy_reset_long_cycles_p = pmc_pkg::phy_reset_long_cycles
) (
  input wire logic i_clk,
  input wire logic i_reset_n,
  input wire logic [7:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [31:0] o_rdata,
  input wire logic i_lpi_wake_event,
  input wire logic i_resume_done,
  input wire logic i_resume_remote,
  input wire logic i_unconfigured,
  input wire logic i_config_loaded,
  input wire logic i_mac_rx_clk_running,
  input wire logic i_mac_tx_clk_running,
  output logic o_lpi_wake_request,
  output logic o_clear_wake_flags,
  output logic o_clear_wake_cause_bit1,
  output logic o_clear_wake_enables,
  output logic o_osc_suspend_block,
  output logic o_analog_ref_on,
  output logic o_phy_reset,
  output logic o_mac_rx_reset,
  output logic o_mac_tx_reset,
  output logic [1:0] o_sleep_mode,
  output logic o_ready
);
  import pmc_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  logic skip_wait_reg;
  logic osc_block_reg;
  logic lpi_en_reg;
  logic lpi_flag_reg;
  logic mac_rst_reg;
  logic clr_sts_reg;
  logic clr_en_reg;
  logic phy_reset_pulse_reg;
  logic settle_reg;
  logic [1:0] mode_reg;
  logic rx_run;
  logic tx_run;
  logic phy_busy;
  logic [23:0] phy_load;
  logic mac_rx_reg;
  logic mac_tx_reg;

  wire sel = (i_addr == power_mgmt_control_addr);
  wire wr_hit = i_wr && sel;
  wire remote_done = i_resume_done && i_resume_remote;
  wire clr_flags = remote_done && clr_sts_reg;
  wire clr_enables = remote_done && clr_en_reg;
  wire phy_start = wr_hit && i_wdata[phy_reset_pulse_bit] && !phy_reset_pulse_reg;
  wire flag_wclr = wr_hit && i_wdata[lpi_wake_flag_bit];
  // a reset started by a write follows the reference choice written with it
  wire new_skip = i_wdata[skip_analog_ref_wait_bit];

  // long pulse covers the reference settle time when it was turned off
  assign phy_load = new_skip ? cnt_w'(phy_reset_min_cycles_p)
                             : cnt_w'(phy_reset_long_cycles_p);

  pmc_timer u_phy_timer (
    .i_clk(i_clk),
    .i_reset_n(i_reset_n),
    .i_start(phy_start),
    .i_load(phy_load),
    .o_busy(phy_busy)
  );

  pmc_sync3 u_rx_sync (
    .i_clk(i_clk),
    .i_reset_n(i_reset_n),
    .i_async(i_mac_rx_clk_running),
    .o_level(rx_run)
  );

  pmc_sync3 u_tx_sync (
    .i_clk(i_clk),
    .i_reset_n(i_reset_n),
    .i_async(i_mac_tx_clk_running),
    .o_level(tx_run)
  );

  ////////////////////////////////////////////////////////////////////////////
  // plain read/write configuration bits
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      skip_wait_reg <= skip_analog_ref_wait_reset;
    end else if (wr_hit) begin
      skip_wait_reg <= new_skip;
    end
  end

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      osc_block_reg <= 1'b0;
    end else if (wr_hit) begin
      osc_block_reg <= i_wdata[osc_suspend_block_bit];
    end
  end

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      mac_rst_reg <= 1'b0;
    end else if (wr_hit) begin
      mac_rst_reg <= i_wdata[mac_domain_reset_bit];
    end
  end

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      clr_sts_reg <= 1'b0;
    end else if (wr_hit) begin
      clr_sts_reg <= i_wdata[resume_clears_wake_flags_bit];
    end
  end

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      clr_en_reg <= resume_clears_wake_enables_reset;
    end else if (wr_hit) begin
      clr_en_reg <= i_wdata[resume_clears_wake_enables_bit];
    end
  end

  // a resume that clears enables wins over a write in the same cycle
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      lpi_en_reg <= 1'b0;
    end else if (clr_enables) begin
      lpi_en_reg <= 1'b0;
    end else if (wr_hit) begin
      lpi_en_reg <= i_wdata[lpi_wake_enable_bit];
    end
  end

  // an unconfigured device falls back to sleep state two over any write
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      mode_reg <= sleep_mode_reset;
    end else if (i_unconfigured) begin
      mode_reg <= sleep_mode_reset;
    end else if (wr_hit) begin
      mode_reg <= i_wdata[sleep_mode_lsb +: 2];
    end
  end

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      lpi_flag_reg <= 1'b0;
    end else if (i_lpi_wake_event) begin
      lpi_flag_reg <= 1'b1;
    end else if (clr_flags || flag_wclr) begin
      lpi_flag_reg <= 1'b0;
    end
  end

  // phy reset stays high until timer expires; settle flag marks reference off
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      phy_reset_pulse_reg <= 1'b0;
      settle_reg <= 1'b0;
    end else if (phy_start) begin
      phy_reset_pulse_reg <= 1'b1;
      settle_reg <= !new_skip;
    end else if (phy_reset_pulse_reg && !phy_busy) begin
      phy_reset_pulse_reg <= 1'b0;
      settle_reg <= 1'b0;
    end
  end

  // each domain leaves reset only when its clock is seen running
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      mac_rx_reg <= 1'b1;
      mac_tx_reg <= 1'b1;
    end else begin
      mac_rx_reg <= mac_rst_reg || !rx_run;
      mac_tx_reg <= mac_rst_reg || !tx_run;
    end
  end

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_ready <= 1'b0;
    end else begin
      o_ready <= !phy_reset_pulse_reg && !phy_start && i_config_loaded;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  wire [31:0] reg_value = {16'h0000, skip_wait_reg, osc_block_reg, lpi_en_reg, lpi_flag_reg,
                           mac_rst_reg, 1'b0, clr_sts_reg, clr_en_reg, o_ready, mode_reg,
                           phy_reset_pulse_reg, 4'h0};

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_rdata <= 32'h00000000;
    end else if (i_rd && sel) begin
      o_rdata <= reg_value;
    end else begin
      o_rdata <= 32'h00000000;
    end
  end

  assign o_lpi_wake_request = lpi_en_reg && lpi_flag_reg;
  assign o_clear_wake_flags = clr_flags;
  assign o_clear_wake_cause_bit1 = clr_flags;
  assign o_clear_wake_enables = clr_enables;
  assign o_osc_suspend_block = osc_block_reg;
  assign o_analog_ref_on = !phy_reset_pulse_reg || !settle_reg;
  assign o_phy_reset = phy_reset_pulse_reg;
  assign o_mac_rx_reset = mac_rx_reg;
  assign o_mac_tx_reset = mac_tx_reg;
  assign o_sleep_mode = mode_reg;

  ////////////////////////////////////////////////////////////////////////////
  a_flag_set_wins: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    i_lpi_wake_event |=> lpi_flag_reg)
    else $error("idle wake flag lost");
  a_flag_resume_clr: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    clr_flags && !i_lpi_wake_event |=> !lpi_flag_reg)
    else $error("flag not cleared");
  a_flag_write_clr: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    flag_wclr && !i_lpi_wake_event |=> !lpi_flag_reg)
    else $error("flag not cleared by write");
  a_host_resume_keeps: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    i_resume_done && !i_resume_remote |-> !o_clear_wake_flags && !o_clear_wake_enables)
    else $error("host resume cleared wake state");
  a_enable_resume_clr: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    clr_enables |=> !lpi_en_reg)
    else $error("enable not cleared");
  a_enable_write_set: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    wr_hit && !clr_enables && i_wdata[lpi_wake_enable_bit] |=> lpi_en_reg)
    else $error("enable not written");
  a_mac_held_reset: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    mac_rst_reg |=> o_mac_rx_reset && o_mac_tx_reset)
    else $error("mac not in reset");
  a_mac_clock_gate: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    !rx_run |=> o_mac_rx_reset)
    else $error("rx reset released without clock");
  a_tx_clock_gate: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    !tx_run |=> o_mac_tx_reset)
    else $error("tx reset released without clock");
  a_ready_phy_low: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    phy_reset_pulse_reg |=> !o_ready)
    else $error("ready during phy reset");
  a_ready_start_low: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    phy_start |=> !o_ready)
    else $error("ready at phy reset start");
  a_ready_config_low: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    !i_config_loaded |=> !o_ready)
    else $error("ready before config load");
  a_ready_after_phy: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    $fell(phy_reset_pulse_reg) && i_config_loaded && !phy_start |=> o_ready)
    else $error("ready not raised after phy reset");
  a_phy_min_pulse: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    $rose(phy_reset_pulse_reg) |-> phy_reset_pulse_reg[*8])
    else $error("phy reset too short");
  a_phy_hold_busy: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    phy_reset_pulse_reg && phy_busy |=> phy_reset_pulse_reg)
    else $error("phy reset ended early");
  a_mode_unconfig: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    i_unconfigured |=> o_sleep_mode == 2'h2)
    else $error("mode not restored");
  a_mode_write_zero: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    wr_hit && !i_unconfigured && i_wdata[sleep_mode_lsb +: 2] == 2'h0 |=> o_sleep_mode == 2'h0)
    else $error("mode not written");
  a_ref_held_on: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    new_skip && phy_start |=> o_analog_ref_on)
    else $error("reference dropped");
  a_ref_off_wait: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    !new_skip && phy_start |=> !o_analog_ref_on)
    else $error("reference kept on");
  a_osc_follow_write: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    wr_hit && i_wdata[osc_suspend_block_bit] |=> o_osc_suspend_block)
    else $error("crystal hold not written");
  a_reserved_zero: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    o_rdata[31:16] == 16'h0000 && !o_rdata[10] && o_rdata[3:0] == 4'h0)
    else $error("reserved read data bit set");
  a_rdata_idle: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    !(i_rd && sel) |=> o_rdata == 32'h00000000)
    else $error("read data outside read cycle");
endmodule // power_mgmt_control_reg
`default_nettype wire

// file: tb/power_mgmt_control_reg_tb.sv
`timescale 1ns/10ps
`default_nettype none
module power_mgmt_control_reg_tb;
  import pmc_pkg::*;
  localparam int min_c = 10;
  localparam int long_c = 40;
  logic i_clk = 1'b0;
  logic i_reset_n = 1'b0;
  logic [7:0] i_addr = 8'h00;
  logic [31:0] i_wdata = 32'h0;
  logic i_wr = 1'b0, i_rd = 1'b0, i_lpi_wake_event = 1'b0, i_resume_done = 1'b0;
  logic i_resume_remote = 1'b0, i_unconfigured = 1'b0, i_config_loaded = 1'b0;
  logic i_mac_rx_clk_running = 1'b1, i_mac_tx_clk_running = 1'b1;
  logic [31:0] o_rdata;
  logic o_lpi_wake_request, o_clear_wake_flags, o_clear_wake_cause_bit1;
  logic o_clear_wake_enables, o_osc_suspend_block, o_analog_ref_on, o_phy_reset;
  logic o_mac_rx_reset, o_mac_tx_reset, o_ready;
  logic [1:0] o_sleep_mode;
  logic [31:0] sh, seed;
  logic rdy;
  int fail_count = 0, total_checks = 0, cyc = 0, n;
  ////////////////////////////////////////////////////////////////////////////////
  power_mgmt_control_reg #(.phy_reset_min_cycles_p(min_c), .phy_reset_long_cycles_p(long_c)) dut (
    .i_clk(i_clk), .i_reset_n(i_reset_n), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
    .i_rd(i_rd), .o_rdata(o_rdata), .i_lpi_wake_event(i_lpi_wake_event),
    .i_resume_done(i_resume_done), .i_resume_remote(i_resume_remote),
    .i_unconfigured(i_unconfigured), .i_config_loaded(i_config_loaded),
    .i_mac_rx_clk_running(i_mac_rx_clk_running), .i_mac_tx_clk_running(i_mac_tx_clk_running),
    .o_lpi_wake_request(o_lpi_wake_request), .o_clear_wake_flags(o_clear_wake_flags),
    .o_clear_wake_cause_bit1(o_clear_wake_cause_bit1),
    .o_clear_wake_enables(o_clear_wake_enables), .o_osc_suspend_block(o_osc_suspend_block),
    .o_analog_ref_on(o_analog_ref_on), .o_phy_reset(o_phy_reset),
    .o_mac_rx_reset(o_mac_rx_reset), .o_mac_tx_reset(o_mac_tx_reset),
    .o_sleep_mode(o_sleep_mode), .o_ready(o_ready));
  ////////////////////////////////////////////////////////////////////////////////
  always #12.5 i_clk = ~i_clk;
  function automatic logic [31:0] ex();
    return sh | (rdy ? 32'h80 : 32'h0);
  endfunction
  task automatic stop_test();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  always @(posedge i_clk) begin
    cyc++;
    if (cyc == 5000) begin
      fail_count++;
      stop_test();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [31:0] d);
    @(posedge i_clk);
    i_addr <= 8'h14;
    i_wdata <= d;
    i_wr <= 1'b1;
    @(posedge i_clk);
    i_wr <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge i_clk);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_clk);
    i_rd <= 1'b0;
    #1;
    chk(o_rdata, e);
  endtask
  task automatic ev();
    @(posedge i_clk);
    i_lpi_wake_event <= 1'b1;
    @(posedge i_clk);
    i_lpi_wake_event <= 1'b0;
    #1;
  endtask
  task automatic res(input logic r, input logic [2:0] e);
    @(posedge i_clk);
    i_resume_done <= 1'b1;
    i_resume_remote <= r;
    #1;
    chk(32'({o_clear_wake_flags, o_clear_wake_cause_bit1, o_clear_wake_enables}), 32'(e));
    @(posedge i_clk);
    i_resume_done <= 1'b0;
    #1;
  endtask
  task automatic phy(input logic keep, input int len);
    sh = {16'h0, keep, 15'h0040};
    wr(sh | 32'h10);
    chk(32'({o_phy_reset, o_ready, o_analog_ref_on}), 32'({2'b10, keep}));
    n = 0;
    while (o_phy_reset === 1'b1 && n < 200) begin
      @(posedge i_clk);
      #1;
      n++;
    end
    chk(32'(n >= len && n <= len + 1), 32'h1);
    repeat (2) @(posedge i_clk);
    #1;
    chk(32'({o_ready, o_analog_ref_on}), 32'h3);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    seed = 32'he339;
    repeat (12) @(posedge i_clk);
    i_reset_n <= 1'b1;
    sh = 32'h140;
    rdy = 1'b0;
    rd(8'h14, ex());
    repeat (6) @(posedge i_clk);
    #1;
    chk(32'({o_mac_rx_reset, o_mac_tx_reset}), 32'h0);
    for (int k = 0; k < 16; k++) begin
      sh = $random(seed) & 32'hEB60;
      wr(sh);
      chk(32'({o_osc_suspend_block, o_sleep_mode, o_analog_ref_on}), 32'({sh[14], sh[6:5], 1'b1}));
      if (sh[11]) begin
        @(posedge i_clk);
        #1;
        chk(32'({o_mac_rx_reset, o_mac_tx_reset}), 32'h3);
      end
      rd(8'h14, ex());
    end
    rd(8'h20, 32'h0);
    sh = 32'h0;
    wr(32'hFFFF048F);
    rd(8'h14, ex());
    sh = 32'h800;
    wr(sh);
    @(posedge i_clk);
    #1;
    chk(32'({o_mac_rx_reset, o_mac_tx_reset}), 32'h3);
    sh = 32'h0;
    wr(sh);
    repeat (6) @(posedge i_clk);
    #1;
    chk(32'({o_mac_rx_reset, o_mac_tx_reset}), 32'h0);
    i_mac_tx_clk_running <= 1'b0;
    repeat (6) @(posedge i_clk);
    #1;
    chk(32'({o_mac_rx_reset, o_mac_tx_reset}), 32'h1);
    i_mac_tx_clk_running <= 1'b1;
    sh = 32'h2340;
    wr(sh);
    ev();
    chk(32'(o_lpi_wake_request), 32'h1);
    res(1'b0, 3'b000);
    rd(8'h14, ex() | 32'h1000);
    res(1'b1, 3'b111);
    sh = 32'h340;
    rd(8'h14, ex());
    sh = 32'h2040;
    wr(sh);
    ev();
    res(1'b1, 3'b000);
    rd(8'h14, ex() | 32'h1000);
    wr(sh | 32'h1000); // flag cleared with the sleep mode field left as it stands
    rd(8'h14, ex());
    sh = 32'h0;
    wr(sh);
    @(posedge i_clk);
    i_unconfigured <= 1'b1;
    @(posedge i_clk);
    i_unconfigured <= 1'b0;
    #1;
    chk(32'(o_sleep_mode), 32'h2);
    sh = 32'h40;
    rd(8'h14, ex());
    i_config_loaded <= 1'b1;
    repeat (3) @(posedge i_clk);
    rdy = 1'b1;
    rd(8'h14, ex());
    phy(1'b1, min_c);
    phy(1'b0, long_c);
    stop_test();
  end
endmodule // power_mgmt_control_reg_tb
`default_nettype wire
